// [verilog/ubm_top.sv]
// Purpose: User break unit: matches CPU and DMA bus cycles, raises a break.
// Assumes: AXI4-Lite register slave, one clock, synchronous low reset.
// Notes: Standby does not touch the registers; only reset clears them.
//
// How it works
// - Each monitored cycle is checked; a hit raises the user break request.
// - Conditions: address, CPU or DMA, fetch or data, read or write, size.
// - A fetch hit tags the instruction so the break precedes its execution.
// - High address register holds bits 31-16, low register bits 15-0.
// - Address registers reset to zero and survive standby.
// - Each address register is sixteen bits, readable and writable.
// - Only index bits 27-24 and 8-0 decode; bits 23-9 are ignored.
// - A set mask bit drops that address bit from the comparison.
// - Cycle select register picks master, type, direction, size; reset clears.
`timescale 1ns/1ps
`include "ubm_consts.svh"

module ubm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ubm_pkg::ubm_cycle_type mon_cycle,
    output logic brk_fetch_tag,
    output logic brk_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Address to register; index bits 23-9 take no part
    function automatic ubm_pkg::ubm_sel_type decode(input logic [31:0] addr);
        logic [27:0] idx;
        idx = addr[29:2];
        decode = ubm_pkg::SEL_NONE;
        if (idx[27:24] == 4'(`UBM_IDX_BAH >> 24)) begin
            case (idx[8:0])
                9'(`UBM_IDX_BAH): decode = ubm_pkg::SEL_BAH;
                9'(`UBM_IDX_BAL): decode = ubm_pkg::SEL_BAL;
                9'(`UBM_IDX_MH): decode = ubm_pkg::SEL_MH;
                9'(`UBM_IDX_ML): decode = ubm_pkg::SEL_ML;
                9'(`UBM_IDX_CYC): decode = ubm_pkg::SEL_CYC;
                9'(`UBM_IDX_STAT): decode = ubm_pkg::SEL_STAT;
                9'(`UBM_IDX_CLR): decode = ubm_pkg::SEL_CLR;
                9'(`UBM_IDX_EN): decode = ubm_pkg::SEL_EN;
                default: decode = ubm_pkg::SEL_NONE;
            endcase
        end
    endfunction : decode

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16[7:0] = strb[0] ? d[7:0] : old[7:0];
        merge16[15:8] = strb[1] ? d[15:8] : old[15:8];
    endfunction : merge16

    // Two-bit select field: bit 0 allows the first case, bit 1 the second
    function automatic logic field_hit(input logic [1:0] sel, input logic second);
        field_hit = second ? sel[1] : sel[0];
    endfunction : field_hit

    ////////////////////////////////////////////////////////////////////////////
    // Registers and match state

    logic [15:0] bah_reg;
    logic [15:0] bal_reg;
    logic [15:0] mh_reg;
    logic [15:0] ml_reg;
    logic [15:0] csel_reg;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] en_reg;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic addr_hit;
    logic cond_hit;
    logic cycle_hit;
    logic [31:0] brk_addr;
    logic [31:0] brk_mask;
    logic [1:0] sz_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    logic aw_full_reg;
    logic w_full_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_do;
    ubm_pkg::ubm_sel_type wr_sel;

    // Address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_sel = decode(awaddr_reg);

    // Address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= 32'h00000000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_full_reg <= 1'b0;
        end
    end

    // Data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_do) begin
            w_full_reg <= 1'b0;
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `UBM_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == ubm_pkg::SEL_NONE) ? `UBM_RESP_SLVERR : `UBM_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Break condition registers; only reset clears them, standby keeps them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bah_reg <= `UBM_RST16;
            bal_reg <= `UBM_RST16;
            mh_reg <= `UBM_RST16;
            ml_reg <= `UBM_RST16;
            csel_reg <= `UBM_RST16;
            en_reg <= `UBM_RST_EV;
        end else if (wr_do) begin
            case (wr_sel)
                ubm_pkg::SEL_BAH: bah_reg <= merge16(bah_reg, wdata_reg, wstrb_reg);
                ubm_pkg::SEL_BAL: bal_reg <= merge16(bal_reg, wdata_reg, wstrb_reg);
                ubm_pkg::SEL_MH: mh_reg <= merge16(mh_reg, wdata_reg, wstrb_reg);
                ubm_pkg::SEL_ML: ml_reg <= merge16(ml_reg, wdata_reg, wstrb_reg);
                ubm_pkg::SEL_CYC: csel_reg <= merge16(csel_reg, wdata_reg, wstrb_reg);
                ubm_pkg::SEL_EN: begin
                    if (wstrb_reg[0]) begin
                        en_reg <= wdata_reg[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    ubm_pkg::ubm_rd_state_type rd_state_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    assign s_axi_arready = (rd_state_reg == ubm_pkg::RD_IDLE);
    assign s_axi_rvalid = (rd_state_reg == ubm_pkg::RD_RESP);
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Data captured at the address; upper half reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= ubm_pkg::RD_IDLE;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `UBM_RESP_OKAY;
        end else begin
            case (rd_state_reg)
                ubm_pkg::RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_reg <= ubm_pkg::RD_RESP;
                        rresp_reg <= `UBM_RESP_OKAY;
                        case (decode(s_axi_araddr))
                            ubm_pkg::SEL_BAH: rdata_reg <= {16'h0000, bah_reg};
                            ubm_pkg::SEL_BAL: rdata_reg <= {16'h0000, bal_reg};
                            ubm_pkg::SEL_MH: rdata_reg <= {16'h0000, mh_reg};
                            ubm_pkg::SEL_ML: rdata_reg <= {16'h0000, ml_reg};
                            ubm_pkg::SEL_CYC: rdata_reg <= {16'h0000, csel_reg};
                            ubm_pkg::SEL_STAT: rdata_reg <= {30'h00000000, stat_reg};
                            ubm_pkg::SEL_EN: rdata_reg <= {30'h00000000, en_reg};
                            ubm_pkg::SEL_CLR: rdata_reg <= 32'h00000000;
                            default: begin
                                rdata_reg <= 32'h00000000;
                                rresp_reg <= `UBM_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                ubm_pkg::RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= ubm_pkg::RD_IDLE;
                    end
                end
                default: rd_state_reg <= ubm_pkg::RD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Break matching

    // Upper register covers bits 31-16, lower bits 15-0
    assign brk_addr = {bah_reg, bal_reg};
    assign brk_mask = {mh_reg, ml_reg};
    assign sz_sel = csel_reg[`UBM_CSEL_SZ_LSB +: 2];

    // Masked bits never cause a miss
    assign addr_hit = (((mon_cycle.addr ^ brk_addr) & ~brk_mask) == 32'h00000000);

    // Select 00 in master, type or direction disables the break entirely
    always_comb begin
        cond_hit = field_hit(csel_reg[`UBM_CSEL_CD_LSB +: 2], mon_cycle.is_dma)
            && field_hit(csel_reg[`UBM_CSEL_ID_LSB +: 2], !mon_cycle.is_fetch)
            && field_hit(csel_reg[`UBM_CSEL_RW_LSB +: 2], mon_cycle.is_write);
        if (sz_sel != 2'h0 && sz_sel != 2'(mon_cycle.size + 2'h1)) begin
            cond_hit = 1'b0;
        end
    end

    assign cycle_hit = mon_cycle.valid && addr_hit && cond_hit;

    // Events; a fetch hit is also reported to hold the instruction back
    assign ev_set[`UBM_EV_MATCH] = cycle_hit;
    assign ev_set[`UBM_EV_FETCH] = cycle_hit && mon_cycle.is_fetch;
    assign ev_clr = (wr_do && wr_sel == ubm_pkg::SEL_CLR && wstrb_reg[0])
        ? wdata_reg[1:0] : 2'h0;
    // A new event wins over a clear in the same cycle
    assign stat_next = (stat_reg & ~ev_clr) | ev_set;

    // Sticky status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= `UBM_RST_EV;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // Tag follows the fetch by one cycle, before the fetched word can issue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_fetch_tag <= 1'b0;
        end else begin
            brk_fetch_tag <= ev_set[`UBM_EV_FETCH];
        end
    end

    // Level request to the CPU while an enabled event stands
    assign brk_irq = |(stat_reg & en_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_low_s;
        wr_do && wr_sel == ubm_pkg::SEL_BAL && wstrb_reg[1:0] == 2'h3;
    endsequence

    sequence wr_high_alias_s;
        wr_do && awaddr_reg[29:26] == 4'h5 && awaddr_reg[10:2] == 9'h190
            && wstrb_reg[1:0] == 2'h3;
    endsequence

    // An enable write in the hit cycle may legally drop the request
    match_sets_irq_a: assert property (cycle_hit && en_reg[0]
        && !(wr_do && wr_sel == ubm_pkg::SEL_EN) |=> stat_reg[0] && brk_irq)
        else $error("break hit did not raise request");

    sizes_select_a: assert property (cycle_hit && sz_sel != 2'h0 |->
        sz_sel == mon_cycle.size + 2'h1)
        else $error("break on wrong operand size");

    fetch_tag_a: assert property (ev_set[1] |=> brk_fetch_tag && stat_reg[1])
        else $error("fetch break not tagged");

    halves_split_a: assert property (addr_hit && brk_mask == 32'h00000000 |->
        mon_cycle.addr[31:16] == bah_reg && mon_cycle.addr[15:0] == bal_reg)
        else $error("address halves misplaced");

    reset_clears_a: assert property (!$past(aresetn) |-> bah_reg == 16'h0000
        && bal_reg == 16'h0000)
        else $error("address registers not cleared");

    low_write_a: assert property (wr_low_s |=> bal_reg == 16'($past(wdata_reg)))
        else $error("low address write lost");

    alias_decode_a: assert property (wr_high_alias_s |=>
        bah_reg == 16'($past(wdata_reg)))
        else $error("aliased address not decoded");

    mask_all_a: assert property (brk_mask == 32'hFFFFFFFF |-> addr_hit)
        else $error("masked bits still compared");

    // Guarded against a select write that lands in the second cycle
    select_off_a: assert property ((csel_reg[7:6] == 2'h0
        || csel_reg[5:4] == 2'h0 || csel_reg[3:2] == 2'h0)
        && !(wr_do && wr_sel == ubm_pkg::SEL_CYC) |-> !cycle_hit [*2])
        else $error("break with cycle select cleared");

    all_fields_a: assert property (ev_set[0] |-> addr_hit && cond_hit
        && mon_cycle.valid)
        else $error("break without full condition");

endmodule : ubm_top

// [verilog/ubm_consts.svh]
// Purpose: Constants of the user break address matcher.
// Assumes: Included by its bare name.
// Notes: Offsets are register indices; byte address is four times the index.
`ifndef UBM_CONSTS_SVH
`define UBM_CONSTS_SVH

// Register indices
`define UBM_IDX_BAH 28'h5FFFF90
`define UBM_IDX_BAL 28'h5FFFF92
`define UBM_IDX_MH 28'h5FFFF94
`define UBM_IDX_ML 28'h5FFFF96
`define UBM_IDX_CYC 28'h5FFFF98
`define UBM_IDX_STAT 28'h5FFFFA0
`define UBM_IDX_CLR 28'h5FFFFA2
`define UBM_IDX_EN 28'h5FFFFA4

// Reset values
`define UBM_RST16 16'h0000
`define UBM_RST_EV 2'h0

// Cycle select fields: lsb of each two-bit field
`define UBM_CSEL_SZ_LSB 0
`define UBM_CSEL_RW_LSB 2
`define UBM_CSEL_ID_LSB 4
`define UBM_CSEL_CD_LSB 6

// Event bits of status, clear and enable
`define UBM_EV_MATCH 0
`define UBM_EV_FETCH 1

// Bus responses
`define UBM_RESP_OKAY 2'h0
`define UBM_RESP_SLVERR 2'h2
`endif

// [verilog/ubm_pkg.sv]
// Purpose: Types of the user break address matcher.
// Assumes: Constants live in ubm_consts.svh.
// Notes: Size code of a bus cycle: 0 byte, 1 word, 2 long word.
package ubm_pkg;

    // One monitored bus cycle of the CPU or the DMA controller
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic is_dma;
        logic is_fetch;
        logic is_write;
        logic [1:0] size;
    } ubm_cycle_type;

    // Register selected by a bus address
    typedef enum logic [3:0] {
        SEL_BAH,
        SEL_BAL,
        SEL_MH,
        SEL_ML,
        SEL_CYC,
        SEL_STAT,
        SEL_CLR,
        SEL_EN,
        SEL_NONE
    } ubm_sel_type;

    // Read channel states
    typedef enum logic {
        RD_IDLE,
        RD_RESP
    } ubm_rd_state_type;

endpackage : ubm_pkg

// [sim/ubm_bus_src.sv]
// Purpose: Model of the CPU and DMA controller bus cycles that the break unit watches.
// Assumes: Each launch becomes one bus cycle at the next rising edge.
// Notes: Idle cycles flip the address so a stale value can never hit.
`timescale 1ns/1ps

module ubm_bus_src (
    input wire logic aclk,
    input wire logic launch,
    input wire ubm_pkg::ubm_cycle_type cyc_in,
    output ubm_pkg::ubm_cycle_type mon_cycle
);
    // Quiet bus at time zero
    initial mon_cycle = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // One cycle per launch; otherwise invalid with a changing address
    always @(posedge aclk) begin
        if (launch) begin
            mon_cycle <= cyc_in;
        end else begin
            mon_cycle.valid <= 1'b0;
            mon_cycle.addr <= ~mon_cycle.addr;
        end
    end
endmodule : ubm_bus_src

// [sim/user_break_address_matcher_tb.sv]
// Purpose: Self-checking bench of the break unit over its register bus.
// Assumes: Byte address is four times the register index.
// Notes: Cycle select layout and event bits as the designer chose them.
`timescale 1ns/1ps
`include "ubm_consts.svh"

module user_break_address_matcher_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, brk_fetch_tag, brk_irq;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic launch = 1'b0;
    ubm_pkg::ubm_cycle_type cyc = '0;
    ubm_pkg::ubm_cycle_type mon_cycle;
    int errors = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    logic [31:0] rv;
    logic [1:0] rr;

    // Clock at 100 MHz
    always #5 aclk = ~aclk;

    ubm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mon_cycle(mon_cycle), .brk_fetch_tag(brk_fetch_tag),
        .brk_irq(brk_irq));

    ubm_bus_src bus_src (.aclk(aclk), .launch(launch), .cyc_in(cyc), .mon_cycle(mon_cycle));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, the single exit of the run
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // Compare one value; four-state equality so unknowns fail
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Byte address of a register index
    function automatic logic [31:0] ba(input logic [27:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // Write: address and data offered together, each released when taken.
    // Handshakes are judged at the falling edge, where all is settled, so
    // the bench never races the design at the rising edge. bready stays
    // high, so back-to-back writes never toggle it within one time step.
    task automatic wr(input logic [27:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        logic [1:0] resp;
        awaddr <= ba(idx);
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        resp = 2'h0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && (awready === 1'b1);
            w_hs = wvalid && (wready === 1'b1);
            b_hs = bready && (bvalid === 1'b1);
            resp = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        chk("bresp", resp, er);
    endtask : wr

    // Read: request held until taken, data taken at the edge of rvalid
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs;
        logic r_hs;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        d = 32'h0;
        r = 2'h0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && (arready === 1'b1);
            r_hs = rready && (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end
    endtask : rd

    // One monitored cycle; exp is {fetch hit, any hit}; status cleared after
    task automatic mon(input logic [31:0] a, input logic dma, input logic fet,
                       input logic wrt, input logic [1:0] sz, input logic [1:0] exp);
        cyc <= '{1'b1, a, dma, fet, wrt, sz};
        launch <= 1'b1;
        @(posedge aclk);
        launch <= 1'b0;
        @(posedge aclk);
        #1;
        chk("fetch_tag", brk_fetch_tag, exp[1]);
        chk("irq", brk_irq, |exp);
        @(posedge aclk);
        rd(ba(`UBM_IDX_STAT), rv, rr);
        chk("status", rv, exp);
        wr(`UBM_IDX_CLR, 32'h3, `UBM_RESP_OKAY);
    endtask : mon

    // Hang guard
    always @(posedge aclk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(ba(`UBM_IDX_BAH + 28'(2 * i)), rv, rr);
            chk("reset value", rv, 32'h0);
        end
        wr(`UBM_IDX_BAH ^ 28'h0100000, 32'h0000BEEF, `UBM_RESP_OKAY);
        rd(ba(`UBM_IDX_BAH), rv, rr);
        chk("alias write", rv, 32'hBEEF);
        wr(`UBM_IDX_BAH, 32'hA5A51234, `UBM_RESP_OKAY);
        rd(ba(`UBM_IDX_BAH), rv, rr);
        chk("addr high", rv, 32'h1234);
        rd(ba(`UBM_IDX_BAH ^ 28'h0001000), rv, rr);
        chk("alias", rv, 32'h1234);
        rd(ba(28'h5FFFF9A), rv, rr);
        chk("unmapped rresp", rr, `UBM_RESP_SLVERR);
        chk("unmapped rdata", rv, 32'h0);
        wr(28'h5FFFF9A, 32'h1, `UBM_RESP_SLVERR);
        wr(`UBM_IDX_BAL, 32'hFFFF5678, `UBM_RESP_OKAY);
        rd(ba(`UBM_IDX_BAL), rv, rr);
        chk("addr low", rv, 32'h5678);
        wr(`UBM_IDX_EN, 32'h3, `UBM_RESP_OKAY);
        // CPU, any type, any direction, any size
        wr(`UBM_IDX_CYC, 32'h7C, `UBM_RESP_OKAY);
        mon(32'h12345678, 1'b0, 1'b0, 1'b0, 2'd2, 2'b01);
        mon(32'h12345679, 1'b0, 1'b0, 1'b0, 2'd2, 2'b00);
        mon(32'h12345678, 1'b1, 1'b0, 1'b0, 2'd2, 2'b00);
        wr(`UBM_IDX_ML, 32'h1, `UBM_RESP_OKAY);
        mon(32'h12345679, 1'b0, 1'b0, 1'b0, 2'd2, 2'b01);
        wr(`UBM_IDX_CYC, 32'hFC, `UBM_RESP_OKAY);
        mon(32'h12345678, 1'b1, 1'b0, 1'b1, 2'd0, 2'b01);
        wr(`UBM_IDX_CYC, 32'h5C, `UBM_RESP_OKAY);
        mon(32'h12345678, 1'b0, 1'b1, 1'b0, 2'd1, 2'b11);
        mon(32'h12345678, 1'b0, 1'b0, 1'b0, 2'd1, 2'b00);
        // CPU, writes, long words
        wr(`UBM_IDX_CYC, 32'h7B, `UBM_RESP_OKAY);
        mon(32'h12345678, 1'b0, 1'b0, 1'b1, 2'd2, 2'b01);
        mon(32'h12345678, 1'b0, 1'b0, 1'b1, 2'd0, 2'b00);
        mon(32'h12345678, 1'b0, 1'b0, 1'b0, 2'd2, 2'b00);
        wr(`UBM_IDX_CYC, 32'h3C, `UBM_RESP_OKAY);
        mon(32'h12345678, 1'b0, 1'b0, 1'b0, 2'd2, 2'b00);
        wr(`UBM_IDX_MH, 32'hFFFF, `UBM_RESP_OKAY);
        wr(`UBM_IDX_CYC, 32'h7C, `UBM_RESP_OKAY);
        mon(32'hABCD5679, 1'b0, 1'b0, 1'b0, 2'd2, 2'b01);
        // Whole address masked: only the cycle conditions still decide
        wr(`UBM_IDX_ML, 32'hFFFF, `UBM_RESP_OKAY);
        mon(32'h00000000, 1'b1, 1'b0, 1'b0, 2'd2, 2'b00);
        mon(32'h00000000, 1'b0, 1'b0, 1'b0, 2'd2, 2'b01);
        // Upper byte lane only
        wstrb <= 4'h2;
        wr(`UBM_IDX_BAL, 32'h0000AB00, `UBM_RESP_OKAY);
        wstrb <= 4'hF;
        rd(ba(`UBM_IDX_BAL), rv, rr);
        chk("byte lane", rv, 32'hAB78);
        // Second reset in mid-run clears what was written
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ba(`UBM_IDX_BAL), rv, rr);
        chk("low after reset", rv, 32'h0);
        chk("irq after reset", brk_irq, 32'h0);
        rd(ba(`UBM_IDX_CYC), rv, rr);
        chk("select after reset", rv, 32'h0);
        test_done();
    end
endmodule : user_break_address_matcher_tb
